//--- core/tsi_map.svh
// Named positions, widths, reset values and steps of the switch.
// Assumes it is included by its bare name before the package and core.
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH
`define TSI_NSTREAM   8
`define TSI_NSYNC     10
`define TSI_PER_CHANNEL_LOOPBACK_BIT  15
`define TSI_VC_BIT    14
`define TSI_PC_BIT    13
`define TSI_CCO_BIT   12
`define TSI_OE_BIT    11
`define TSI_SAB_HI    9
`define TSI_SAB_LO    7
`define TSI_CAB_HI    4
`define TSI_CAB_LO    0
`define TSI_BYTE_HI   7
`define TSI_CHAN_HI   7
`define TSI_CHAN_LO   3
`define TSI_SLOT_HI   2
`define TSI_OFS_W     4
`define TSI_DLE_POS   0
`define TSI_OFK_POS   1
`define TSI_OFK_W     3
`define TSI_SYNC_CLK  0
`define TSI_SYNC_FP   1
`define TSI_SYNC_RX   2
`define TSI_LAST_SLOT 3'h7
`define TSI_BIT_STEP  8'h01
`define TSI_CH_STEP   5'h01
`define TSI_BIT_ZERO  8'h00
`define TSI_CM_RESET  16'h0000
`define TSI_OFS_RESET 32'h00000000
`endif

//--- core/tsi_pkg.sv
// Types shared by the time-slot-interchange core.
// Assumes tsi_map.svh is compiled alongside it.
package tsi_pkg;
    typedef logic [15:0] tsi_word_t;   // Connection word
    typedef logic [7:0]  tsi_byte_t;   // Channel data byte
    typedef logic [7:0]  tsi_addr_t;   // {stream, channel}
    typedef logic [2:0]  tsi_strm_t;   // Stream number
    typedef logic [2:0]  tsi_delay_t;  // Measured delay low bits
endpackage : tsi_pkg

//--- core/tsi_switch.sv
// 8-stream, 32-channel time-slot interchange: connection memory,
// data memory, per-stream input offset and control-channel output.
// Assumes host pins are synchronous to REF_CLK; serial pins are not.
`timescale 1ns/1ps
`include "tsi_map.svh"

// Summary of operation
// - Zero offset setting means no input shift
// - Offset field k, latch edge adds half
// - Field from delay bits, edge inverts half
// - Loopback feeds channel input from own output
// - Bit 14 picks variable or constant delay
// - Processor channel sends word contents out
// - Only low byte goes onto output
// - Whole low byte sent, reserved bits too
// - Otherwise word addresses switched input data
// - Control bit output one channel early
// - Control bits emitted stream 0 first
// - Bit 11 enables output driver per channel
// - Bits 9..7 name source stream
// - Bits 4..0 name source channel
// - Half flag set for clock-high sampling
// - Eight input streams, numbered 0 to 7
// - Thirty-two channels per frame
module tsi_switch (
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CLK_EN,
    input  wire logic        SER_CLK,      // Serial bit clock pin
    input  wire logic        FRAME_N,      // Frame pulse, active low
    input  wire logic [7:0]  RX,           // Serial input streams
    output      logic [7:0]  TX,           // Serial output streams
    output      logic [7:0]  TX_OE,        // Output driver enables
    output      logic        CONTROL_CHANNEL_OUT,          // Control channel output
    input  wire logic        HOST_SEL,     // One-cycle host request
    input  wire logic        HOST_WR,      // 1 write, 0 read
    input  wire logic [7:0]  HOST_ADDR,    // {stream, channel}
    input  wire logic [15:0] HOST_WDATA,
    output      logic [15:0] HOST_RDATA,
    output      logic        HOST_ACK,
    input  wire logic        MEAS_LOAD,    // Load measured result
    input  wire logic [2:0]  MEAS_STREAM,
    input  wire logic [2:0]  MEAS_DELAY,
    input  wire logic        MEAS_HALF,
    output      logic [31:0] OFFSET_VIEW   // {k, dle} per stream
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    ////////////////////////////////////////////////////////////////////
    logic [9:0]  s1, s2, s3;                 // Three-stage chains
    logic [9:0]  filt, next_filt;            // Agreed pin levels
    logic        sclk_prev, next_sclk_prev;  // Last agreed clock level
    logic        rise, fall, fp;             // Serial clock edges, frame
    logic [7:0]  rxf;                        // Agreed input data

    genvar g;
    generate
        for (g = 0; g < `TSI_NSYNC; g++)
        begin : g_sync
            // A change counts only once stages two and three agree
            assign next_filt[g] = (s2[g] == s3[g]) ? s3[g] : filt[g];
        end
    endgenerate

    // Register the chains; s1 feeds only s2
    // Chains start at the idle pin level so no false edge follows reset
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            s1        <= '1;
            s2        <= '1;
            s3        <= '1;
            filt      <= '1;
            sclk_prev <= 1'b1;
        end
        else if (CLK_EN)
        begin
            s1        <= {RX, FRAME_N, SER_CLK};
            s2        <= s1;
            s3        <= s2;
            filt      <= next_filt;
            sclk_prev <= next_sclk_prev;
        end
    end

    assign next_sclk_prev = filt[`TSI_SYNC_CLK];
    assign rise = filt[`TSI_SYNC_CLK] & ~sclk_prev;
    assign fall = ~filt[`TSI_SYNC_CLK] & sclk_prev;
    assign fp   = ~filt[`TSI_SYNC_FP];
    assign rxf  = filt[`TSI_NSYNC-1:`TSI_SYNC_RX];

    ////////////////////////////////////////////////////////////////////
    // Frame timing
    ////////////////////////////////////////////////////////////////////
    logic [7:0]  bit_cnt, next_bit_cnt;  // {channel, bit slot}
    logic        bank, next_bank;        // Data bank being written
    logic [7:0]  nc;                     // Bit position after this edge
    logic        nb;                     // Bank after this edge

    // Frame pulse seen on a falling edge restarts channel 0, bit 0
    always_comb
    begin
        nc = bit_cnt;
        nb = bank;
        if (fall)
        begin
            nc = fp ? `TSI_BIT_ZERO : bit_cnt + `TSI_BIT_STEP;
            nb = fp ? ~bank : bank;
        end
        next_bit_cnt = nc;
        next_bank    = nb;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            bit_cnt <= `TSI_BIT_ZERO;
            bank    <= 1'b0;
        end
        else if (CLK_EN)
        begin
            bit_cnt <= next_bit_cnt;
            bank    <= next_bank;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Memories and per-stream decode
    ////////////////////////////////////////////////////////////////////
    tsi_pkg::tsi_word_t cm [256];        // Connection memory
    tsi_pkg::tsi_word_t next_cm [256];
    tsi_pkg::tsi_byte_t dm [2][256];     // Two data banks
    tsi_pkg::tsi_byte_t next_dm [2][256];
    tsi_pkg::tsi_byte_t sh [8];          // Input assembly
    tsi_pkg::tsi_byte_t next_sh [8];
    logic [31:0]        next_ofs;        // Next offset settings
    tsi_pkg::tsi_word_t wo [8];          // Word for next output slot
    tsi_pkg::tsi_byte_t ob [8];          // Byte for next output slot
    logic [7:0]         idx [8];         // Stream-local bit position
    logic [7:0]         ev, lp, rx_eff;  // Sample, loopback, input bit
    logic [7:0]         tx_bit, oe_bit;  // Next output bit, enable
    logic               cco_src;         // Control bit for this slot
    tsi_pkg::tsi_word_t cm_rd;           // Host read port

    generate
        for (g = 0; g < `TSI_NSTREAM; g++)
        begin : g_strm
            tsi_pkg::tsi_addr_t src;
            // One word per output stream and channel slot
            assign wo[g] = cm[{3'(g), nc[`TSI_CHAN_HI:`TSI_CHAN_LO]}];
            // Source stream and channel of a switched connection
            assign src = {wo[g][`TSI_SAB_HI:`TSI_SAB_LO],
                          wo[g][`TSI_CAB_HI:`TSI_CAB_LO]};
            // Processor channel emits the whole low byte as data
            assign ob[g] = wo[g][`TSI_PC_BIT]
                ? wo[g][`TSI_BYTE_HI:0]
                : (wo[g][`TSI_VC_BIT] ? dm[~nb][src]
                                      : dm[nb][src]);
            assign tx_bit[g] = ob[g][`TSI_LAST_SLOT - nc[`TSI_SLOT_HI:0]];
            assign oe_bit[g] = wo[g][`TSI_OE_BIT];
            // Whole-period shift moves the stream's bit zero later
            assign idx[g] = bit_cnt - 8'(OFFSET_VIEW[g*`TSI_OFS_W
                            + `TSI_OFK_POS +: `TSI_OFK_W]);
            // Latch edge set samples half a period later
            assign ev[g] = OFFSET_VIEW[g*`TSI_OFS_W + `TSI_DLE_POS]
                           ? fall : rise;
            assign lp[g] = cm[{3'(g), idx[g][`TSI_CHAN_HI:`TSI_CHAN_LO]}]
                             [`TSI_PER_CHANNEL_LOOPBACK_BIT];
            // Loopback relies on a zero offset for that stream
            assign rx_eff[g] = lp[g] ? TX[g] : rxf[g];
        end
    endgenerate

    assign cco_src = cm[{nc[`TSI_SLOT_HI:0],
                         nc[`TSI_CHAN_HI:`TSI_CHAN_LO] + `TSI_CH_STEP}]
                       [`TSI_CCO_BIT];
    assign cm_rd = cm[HOST_ADDR];

    // Next values of memories, input assembly and offsets
    always_comb
    begin
        next_cm  = cm;
        next_dm  = dm;
        next_sh  = sh;
        next_ofs = OFFSET_VIEW;
        // Host writes land whole; reserved bits are stored as given
        if (HOST_SEL && HOST_WR)
            next_cm[HOST_ADDR] = HOST_WDATA;
        // Measured result: k from delay bits, edge is inverted half flag
        if (MEAS_LOAD)
            next_ofs[MEAS_STREAM*`TSI_OFS_W +: `TSI_OFS_W] =
                {MEAS_DELAY, ~MEAS_HALF};
        for (int n = 0; n < `TSI_NSTREAM; n++)
        begin
            if (ev[n])
            begin
                next_sh[n] = {sh[n][6:0], rx_eff[n]};
                // Last bit of a channel commits the byte to this bank
                if (idx[n][`TSI_SLOT_HI:0] == `TSI_LAST_SLOT)
                    next_dm[bank][{3'(n),
                        idx[n][`TSI_CHAN_HI:`TSI_CHAN_LO]}] = next_sh[n];
            end
        end
    end

    // Register memories and all outputs; serial outputs change on serial fall
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            cm          <= '{default: `TSI_CM_RESET};
            dm          <= '{default: '{default: 8'h00}};
            sh          <= '{default: 8'h00};
            OFFSET_VIEW <= `TSI_OFS_RESET;
            HOST_RDATA  <= `TSI_CM_RESET;
            HOST_ACK    <= 1'b0;
            TX          <= 8'hff;
            TX_OE       <= 8'h00;
            CONTROL_CHANNEL_OUT         <= 1'b0;
        end
        else if (CLK_EN)
        begin
            cm          <= next_cm;
            dm          <= next_dm;
            sh          <= next_sh;
            OFFSET_VIEW <= next_ofs;
            HOST_ACK    <= HOST_SEL;
            if (HOST_SEL && !HOST_WR)
                HOST_RDATA <= cm_rd;
            if (fall)
            begin
                TX    <= tx_bit;
                TX_OE <= oe_bit;
                CONTROL_CHANNEL_OUT   <= cco_src;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    reset_offset_a: assert property ($past(SYS_RST) |->
        OFFSET_VIEW == 32'h00000000)
        else $error("offsets not zero after reset");
    offset_encode_a: assert property ((CLK_EN && MEAS_LOAD &&
        MEAS_STREAM == 3'h0) |=> OFFSET_VIEW[3:0] ==
        {$past(MEAS_DELAY), ~$past(MEAS_HALF)})
        else $error("offset setting not derived from measurement");
    half_edge_a: assert property ((CLK_EN && MEAS_LOAD &&
        MEAS_STREAM == 3'h1 && MEAS_HALF) |=> !OFFSET_VIEW[4])
        else $error("clock-high sample gave a half-period edge");
    loopback_in_a: assert property (lp[4] |->
        rx_eff[4] == TX[4])
        else $error("looped channel not taken from own output");
    pc_byte_a: assert property ((CLK_EN && fall &&
        wo[0][`TSI_PC_BIT]) |=> TX[0] == $past(tx_bit[0]) &&
        $past(ob[0]) == $past(wo[0][`TSI_BYTE_HI:0]))
        else $error("processor channel byte not sent");
    oe_drive_a: assert property ((CLK_EN && fall) |=>
        TX_OE[0] == $past(oe_bit[0]) && TX_OE[3] == $past(oe_bit[3]))
        else $error("output enable not from word bit 11");
    cco_early_a: assert property ((CLK_EN && fall && !fp) ##1
        (!fall throughout CLK_EN [*2]) |-> CONTROL_CHANNEL_OUT == $past(cco_src, 2))
        else $error("control output did not hold its slot");
    host_ack_a: assert property ($past(CLK_EN) |->
        HOST_ACK == $past(HOST_SEL))
        else $error("host answer not one cycle after request");
    host_wrrd_a: assert property ((CLK_EN && HOST_SEL && HOST_WR)
        ##1 (CLK_EN && HOST_SEL && !HOST_WR &&
        HOST_ADDR == $past(HOST_ADDR)) |=>
        HOST_RDATA == $past(HOST_WDATA, 2))
        else $error("written word not read back");

    pc_slot_c:   cover property (CLK_EN && fall && wo[0][`TSI_PC_BIT]);
    loopback_c:  cover property (lp[4] && ev[4]);
    meas_load_c: cover property (CLK_EN && MEAS_LOAD && !MEAS_HALF);
    frame_c:     cover property (CLK_EN && fall && fp);

endmodule : tsi_switch

//--- test/tsi_stream_model.sv
// Serial-side partner: drives bit clock, frame pulse and input streams,
// captures output streams, driver enables and control-channel bits.
// Assumes the bench fills rx_byte before each run_frame call.
`timescale 1ns/1ps
module tsi_stream_model #(
    parameter int HALF = 8              // REF_CLK cycles per clock phase
) (
    input  wire logic       ref_clk,
    input  wire logic [7:0] tx,
    input  wire logic [7:0] tx_oe,
    input  wire logic       control_channel_out,
    output      logic       ser_clk,
    output      logic       frame_n,
    output      logic [7:0] rx
);
    logic [7:0] rx_byte [8][32];        // Bytes to send, per stream/chan
    logic [7:0] tx_byte [8][32];        // Bytes seen on the outputs
    logic [7:0] oe_cap  [32];           // Driver enables per channel
    logic       cco_bit [256];          // Control output per bit time

    ////////////////////////////////////////////////////////////////////
    // Idle: clock stands high between frames, no frame pulse
    initial
    begin
        ser_clk = 1'b1;
        frame_n = 1'b1;
        rx      = 8'h00;
        rx_byte = '{default: 8'h00};
    end

    ////////////////////////////////////////////////////////////////////
    // One frame of 256 bit times; data changes on the fall, MSB first
    task automatic run_frame();
        int b;
        int s;
        for (b = 0; b < 256; b++)
        begin
            @(posedge ref_clk);
            #1;
            ser_clk = 1'b0;
            frame_n = (b == 0) ? 1'b0 : 1'b1;
            for (s = 0; s < 8; s++)
                rx[s] = rx_byte[s][b / 8][7 - b % 8];
            repeat (HALF) @(posedge ref_clk);
            #1;
            frame_n = 1'b1;
            ser_clk = 1'b1;
            // Outputs settled well before the rise, so capture here
            for (s = 0; s < 8; s++)
                tx_byte[s][b / 8][7 - b % 8] = tx[s];
            oe_cap[b / 8] = tx_oe;
            cco_bit[b]    = control_channel_out;
            repeat (HALF - 1) @(posedge ref_clk);
        end
        // Released lines show no stale value
        rx = ~rx;
    endtask : run_frame
endmodule : tsi_stream_model

//--- test/tsi_switch_tb.sv
// Self-checking bench for the time-slot interchange switch.
// Assumes the stream model and all core files are compiled first.
`timescale 1ns/1ps
module tsi_switch_tb;
    logic        ref_clk, sys_rst, clk_en, ser_clk, frame_n, control_channel_out;
    logic        host_sel, host_wr, host_ack, meas_load, meas_half;
    logic [7:0]  rx, tx, tx_oe, host_addr;
    logic [15:0] host_wdata, host_rdata;
    logic [2:0]  meas_stream, meas_delay;
    logic [31:0] offset_view;
    int          n_errors = 0;          // Mismatches seen
    int          checked  = 0;          // Comparisons made

    tsi_switch i_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
        .CLK_EN(clk_en), .SER_CLK(ser_clk), .FRAME_N(frame_n), .RX(rx),
        .TX(tx), .TX_OE(tx_oe), .CONTROL_CHANNEL_OUT(control_channel_out), .HOST_SEL(host_sel),
        .HOST_WR(host_wr), .HOST_ADDR(host_addr),
        .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
        .HOST_ACK(host_ack), .MEAS_LOAD(meas_load),
        .MEAS_STREAM(meas_stream), .MEAS_DELAY(meas_delay),
        .MEAS_HALF(meas_half), .OFFSET_VIEW(offset_view));

    tsi_stream_model i_src (.ref_clk(ref_clk), .tx(tx), .tx_oe(tx_oe),
        .control_channel_out(control_channel_out), .ser_clk(ser_clk), .frame_n(frame_n), .rx(rx));

    ////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////
    // Compare, count and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////
    // One-cycle host request; acknowledge is due the following cycle
    task automatic host(input logic wr, input logic [7:0] a,
        input logic [15:0] d, input logic ack, output logic [15:0] q);
        @(posedge ref_clk);
        #1;
        host_sel   = 1'b1;
        host_wr    = wr;
        host_addr  = a;
        host_wdata = d;
        @(posedge ref_clk);
        #1;
        host_sel = 1'b0;
        check(host_ack, ack);
        q = host_rdata;
    endtask : host

    task automatic meas(input int s, input int dly, input logic half);
        @(posedge ref_clk);
        #1;
        meas_load   = 1'b1;
        meas_stream = 3'(s);
        meas_delay  = 3'(dly);
        meas_half   = half;
        @(posedge ref_clk);
        #1;
        meas_load = 1'b0;
    endtask : meas

    ////////////////////////////////////////////////////////////////////
    // Offset settings k 0 to 4, each with both latch edges, then all streams back to zero
    task automatic t_offsets();
        int i;
        for (i = 0; i < 10; i++)
        begin
            meas(i % 8, i / 2, ~i[0]);
            check(offset_view[4 * (i % 8) +: 4], {3'(i / 2), i[0]});
        end
        // Looped streams need a zero offset field anyway
        for (i = 0; i < 8; i++)
            meas(i, 0, 1'b1);
        check(offset_view, 32'h00000000);
    endtask : t_offsets

    // Reset value, reserved bits kept, request ignored while frozen
    task automatic t_host();
        logic [15:0] q;
        host(1'b0, 8'h9f, 16'h0000, 1'b1, q);
        check(q, 16'h0000);
        host(1'b1, 8'h9f, 16'hffff, 1'b1, q);
        host(1'b0, 8'h9f, 16'h0000, 1'b1, q);
        check(q, 16'hffff);
        // Let the acknowledge fall before freezing the core
        @(posedge ref_clk);
        #1;
        clk_en = 1'b0;
        host(1'b1, 8'h9f, 16'h1234, 1'b0, q);
        clk_en = 1'b1;
        host(1'b0, 8'h9f, 16'h0000, 1'b1, q);
        check(q, 16'hffff);
        // Back-to-back write then read of the same word
        @(posedge ref_clk);
        #1;
        host_sel   = 1'b1;
        host_wr    = 1'b1;
        host_addr  = 8'h9f;
        host_wdata = 16'h0000;
        @(posedge ref_clk);
        #1;
        host_wr = 1'b0;
        check(host_ack, 1'b1);
        @(posedge ref_clk);
        #1;
        host_sel = 1'b0;
        check(host_rdata, 16'h0000);
    endtask : t_host

    // Processor channel, enables, control bits, switching, loopback
    task automatic t_frames();
        logic [15:0] q;
        host(1'b1, 8'h00, 16'h28e5, 1'b1, q);
        host(1'b1, 8'h20, 16'h205a, 1'b1, q);
        host(1'b1, 8'h23, 16'h1000, 1'b1, q);
        host(1'b1, 8'h82, 16'ha85a, 1'b1, q);
        host(1'b1, 8'ha0, 16'h4a02, 1'b1, q);
        host(1'b1, 8'h40, 16'h4985, 1'b1, q);
        host(1'b1, 8'hca, 16'h0985, 1'b1, q);
        i_src.rx_byte[3][5] = 8'h3c;
        i_src.rx_byte[4][2] = 8'hc3;
        i_src.run_frame();
        check(i_src.tx_byte[0][0], 8'he5);
        check(i_src.tx_byte[4][2], 8'h5a);
        check(i_src.oe_cap[0][1:0], 2'b01);
        check({i_src.cco_bit[16], i_src.cco_bit[17], i_src.cco_bit[18]},
            3'b010);
        check(i_src.cco_bit[25], 1'b0);
        check(i_src.tx_byte[6][10], 8'h3c);
        i_src.run_frame();
        check(i_src.tx_byte[2][0], 8'h3c);
        check(i_src.tx_byte[5][0], 8'h5a);
    endtask : t_frames

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {sys_rst, clk_en, host_sel, host_wr, meas_load, meas_half} = 6'h31;
        host_addr   = 8'h00;
        host_wdata  = 16'h0000;
        meas_stream = 3'h0;
        meas_delay  = 3'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        t_offsets();
        t_host();
        t_frames();
        give_verdict();
    end

    // Two frames take about 8200 cycles; allow generous margin
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end
endmodule : tsi_switch_tb
